//--- hw/modem_config_register.sv
// Purpose: 24/48-bit modem configuration register behind an AXI4-Lite slave
// Assumes: One clock, synchronous active-low reset, inputs synchronous to aclk
// Notes:   Drives effective settings and conditioned receive pins
// How it works
// RL1 - Register is 24 bits, 48 when extended
// RL2 - Extended adds freeze, header and length bits
// RL3 - Header matches 16-bit or two 8-bit patterns
// RL4 - Bits 2..0 pick channel, default 132.5 kHz
// RL5 - Bits 4..3 pick symbol rate, default 2400
// RL6 - Bit 6 enables watchdog, default on
// RL7 - Bits 8..7 pick transmit time-out, default 1 s
// RL8 - Bits 10..9 pick detection time, default 1 ms
// RL9 - Bit 11 enables zero-crossing sync, default off
// RL10 - Method 00: carrier on detect, pins free
// RL11 - Method 01: pins low without carrier
// RL12 - Method 10: preamble on detect, default method
// RL13 - Method 11: pins low without preamble or lock
// RL14 - Bit 14 picks mains mode, default asynchronous
// RL15 - Bits 16..15 pick output clock, default 4 MHz
// RL16 - Bit 17 low freezes, only when extended
// RL17 - Bit 18 enables header recognition, only extended
// RL18 - Bit 19 counts frame length, needs 18 and 21
// RL19 - Bit 21 selects 48-bit extended register
// RL20 - UART host mode uses other method encoding
// RL21 - Header detected drives detect output low
// RL22 - Reset loads every field with its default
// RL23 - Host avoids time-out 11 and stray extended bits
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module modem_config_register (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [modem_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [modem_cfg_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [modem_cfg_pkg::STRB_W-1:0] s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [modem_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [modem_cfg_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic                            uart_mode,
    input  wire modem_cfg_pkg::rx_in_type        rx_in,
    output modem_cfg_pkg::rx_out_type            rx_out,
    output modem_cfg_pkg::cfg_type               cfg_eff
);
    import modem_cfg_pkg::*;

    // Register selection codes
    typedef enum logic [1:0] {
        SEL_LO   = 2'b00,
        SEL_HI   = 2'b01,
        SEL_STAT = 2'b10,
        SEL_NONE = 2'b11
    } sel_type;

    // Address decode, shared by read and write paths
    function automatic sel_type decode_addr(input logic [ADDR_W-1:0] a);
        if (a == ADDR_CFG_LO) begin
            return SEL_LO;
        end else if (a == ADDR_CFG_HI) begin
            return SEL_HI;
        end else if (a == ADDR_STATUS) begin
            return SEL_STAT;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [DATA_W-1:0] merge_strb(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    cfg_type             cfg_r;          // Stored configuration word
    logic [ADDR_W-1:0]   awaddr_r;       // Held write address
    logic [DATA_W-1:0]   wdata_r;        // Held write data
    logic [STRB_W-1:0]   wstrb_r;        // Held byte enables
    logic                write_go;       // Both halves present, no answer owed
    sel_type             wsel;           // Decoded write target
    sel_type             rsel;           // Decoded read target
    logic [DATA_W-1:0]   wmerge;         // Held write merged into its target half
    logic [DATA_W-1:0]   rdata_nxt;      // Read mux
    logic [1:0]          rresp_nxt;      // Read response
    hdr_state_type       hdr_state_r;    // Header recognition progress
    logic [CNT_W-1:0]    bit_cnt_r;      // Bits left in counted frame
    logic                rx_clk_q_r;     // Previous bit clock level
    logic                rx_clk_rise;    // Bit clock rising edge
    logic                hdr_rec_act;    // Header recognition in force
    logic                frame_cnt_act;  // Frame counting in force

    // Address and data are held; ready drops once an item is taken
    assign write_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wsel     = decode_addr(awaddr_r);
    // Top byte of the merge is padding and is dropped on store
    assign wmerge   = merge_strb({8'h00, (wsel == SEL_HI) ? cfg_r[CFG_W-1:LO_W]
                                                        : cfg_r[LO_W-1:0]}, wdata_r, wstrb_r);

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            awaddr_r      <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_r      <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, independent of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            wdata_r      <= '0;
            wstrb_r      <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response; status and holes answer with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (write_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == SEL_LO || wsel == SEL_HI) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Configuration storage
    // Upper half only exists in extended mode, so writes there are dropped
    // while the word is 24 bits long; the host sets bit 21 first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= CFG_RESET; // see RL22
        end else if (write_go && wsel == SEL_LO) begin
            // Unused time-out code is stored as written; host keeps clear
            cfg_r[LO_W-1:0] <= wmerge[LO_W-1:0]; // see RL23
        end else if (write_go && wsel == SEL_HI && cfg_r.ext_en) begin
            cfg_r[CFG_W-1:LO_W] <= wmerge[LO_W-1:0]; // see RL1
        end
    end

    // Read mux; upper half reads zero in normal mode
    always_comb begin
        rsel      = decode_addr(s_axi_araddr);
        rdata_nxt = '0;
        rresp_nxt = RESP_OKAY;
        if (rsel == SEL_LO) begin
            rdata_nxt[LO_W-1:0] = cfg_r[LO_W-1:0];
        end else if (rsel == SEL_HI) begin
            if (cfg_r.ext_en) begin
                rdata_nxt[LO_W-1:0] = cfg_r[CFG_W-1:LO_W]; // see RL19
            end
        end else if (rsel == SEL_STAT) begin
            rdata_nxt[7:0] = {hdr_state_r, rx_in.carrier, rx_in.preamble,
                              rx_in.pll_locked, uart_mode, hdr_rec_act, frame_cnt_act};
        end else begin
            rresp_nxt = RESP_SLVERR;
        end
    end

    // Read channel; one read under way, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Extended-only functions gated by bit 21 and, for counting, bit 18
    assign hdr_rec_act   = cfg_r.ext_en && cfg_r.hdr_rec_en; // see RL17
    assign frame_cnt_act = hdr_rec_act && cfg_r.frame_cnt_en; // see RL18

    // Effective settings toward the modem; inactive freeze and header controls show their reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_eff <= CFG_RESET; // see RL22
        end else begin
            cfg_eff              <= cfg_r; // see RL4 see RL5 see RL6 see RL7 see RL8
            cfg_eff.freeze_n     <= cfg_r.freeze_n || !cfg_r.ext_en; // see RL16
            cfg_eff.hdr_rec_en   <= hdr_rec_act; // see RL2
            cfg_eff.frame_cnt_en <= frame_cnt_act;
            cfg_eff.hdr_len16    <= cfg_r.hdr_len16 || !cfg_r.ext_en; // see RL3
            // Zero-crossing, mains mode and clock divider pass as stored
            cfg_eff.zc_sync_en   <= cfg_r.zc_sync_en; // see RL9
            cfg_eff.mains_async  <= cfg_r.mains_async; // see RL14
            cfg_eff.clk_out_sel  <= cfg_r.clk_out_sel; // see RL15
        end
    end

    // Bit clock edge detect; the clock arrives synchronous to aclk
    assign rx_clk_rise = rx_in.clk && !rx_clk_q_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_clk_q_r <= 1'b0;
        end else begin
            rx_clk_q_r <= rx_in.clk;
        end
    end

    // Header recognition: one bit-clock pulse, or a counted frame
    // Frame length zero is not a legal setting; it counts as 256 words.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hdr_state_r <= HDR_IDLE;
            bit_cnt_r   <= '0;
        end else if (!hdr_rec_act) begin
            hdr_state_r <= HDR_IDLE;
        end else begin
            case (hdr_state_r)
                HDR_IDLE: begin
                    if (rx_in.header_hit && frame_cnt_act) begin
                        hdr_state_r <= HDR_FRAME; // see RL3
                        bit_cnt_r   <= CNT_W'(cfg_r.frame_len) * BITS_PER_WORD;
                    end else if (rx_in.header_hit) begin
                        hdr_state_r <= HDR_PULSE; // see RL21
                    end
                end
                HDR_PULSE: begin
                    if (rx_clk_rise) begin
                        hdr_state_r <= HDR_IDLE;
                    end
                end
                HDR_FRAME: begin
                    if (rx_clk_rise && bit_cnt_r == CNT_ONE) begin
                        hdr_state_r <= HDR_IDLE;
                    end
                    if (rx_clk_rise) begin
                        bit_cnt_r <= bit_cnt_r - CNT_ONE;
                    end
                end
                default: begin
                    hdr_state_r <= HDR_IDLE;
                end
            endcase
        end
    end

    // Pin conditioning and output flops
    rx_output_conditioner u_cond (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .method    (cfg_r.det_method),
        .uart_mode (uart_mode),
        .hdr_rec   (hdr_rec_act),
        .hdr_low   (hdr_state_r != HDR_IDLE),
        .hdr_block (frame_cnt_act && hdr_state_r != HDR_FRAME),
        .rx_in     (rx_in),
        .rx_out    (rx_out)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence write_taken_s;
        write_go;
    endsequence

    sequence answer_s;
        s_axi_bvalid ##1 $stable(cfg_r);
    endsequence

    reset_default_a: assert property ( // see RL22
        $rose(aresetn) |-> cfg_r == CFG_RESET && cfg_eff == CFG_RESET)
        else $error("configuration not at defaults after reset");

    write_answer_a: assert property ( // see RL1
        write_taken_s |=> answer_s)
        else $error("write answer missing one cycle after both halves");

    hi_hidden_a: assert property ( // see RL19
        s_axi_arvalid && s_axi_arready && decode_addr(s_axi_araddr) == SEL_HI
        && !cfg_r.ext_en |=> s_axi_rvalid && s_axi_rdata == '0)
        else $error("upper half visible in normal mode");

    hi_locked_a: assert property ( // see RL1
        write_go && wsel == SEL_HI && !cfg_r.ext_en
        |=> $stable(cfg_r[CFG_W-1:LO_W]))
        else $error("upper half written in normal mode");

    freeze_gate_a: assert property ( // see RL16
        !cfg_r.ext_en ##1 !cfg_r.ext_en |-> cfg_eff.freeze_n)
        else $error("freeze active without extended mode");

    count_gate_a: assert property ( // see RL18
        !cfg_r.hdr_rec_en ##1 !cfg_r.hdr_rec_en |-> !cfg_eff.frame_cnt_en)
        else $error("frame counting without header recognition");

    frame_start_a: assert property ( // see RL3
        hdr_state_r == HDR_IDLE && hdr_rec_act && frame_cnt_act && rx_in.header_hit
        |=> hdr_state_r == HDR_FRAME
            && bit_cnt_r == CNT_W'($past(cfg_r.frame_len)) * BITS_PER_WORD)
        else $error("frame count not loaded on header");

    read_hold_a: assert property ( // see RL2
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");

    pulse_detect_a: assert property ( // see RL21
        hdr_state_r == HDR_PULSE && hdr_rec_act
        |=> !rx_out.detect_indication_out)
        else $error("detect not low during header pulse");
endmodule

//--- pkg/modem_cfg_pkg.sv
// Purpose: Shared constants and types for the modem configuration register block
// Assumes: 32-bit AXI4-Lite register bus, one 48-bit configuration word
// Notes:   Configuration layout is a packed struct, low field at bit 0
package modem_cfg_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int LO_W   = 24;                 // Normal-mode register length
    localparam int CFG_W  = 48;                 // Extended-mode register length

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CFG_LO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CFG_HI = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Detection method codes, synchronous serial host mode
    localparam logic [1:0] DET_CARRIER       = 2'b00;
    localparam logic [1:0] DET_CARRIER_COND  = 2'b01;
    localparam logic [1:0] DET_PREAMBLE      = 2'b10;
    localparam logic [1:0] DET_PREAMBLE_COND = 2'b11;
    // Detection method code with conditioning, UART host mode
    localparam logic [1:0] UDET_CARRIER_COND = 2'b11;

    // Frame length counting: bits per counted word
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BITS_PER_WORD = 12'h010;
    localparam logic [CNT_W-1:0] CNT_ONE       = 12'h001;

    // Configuration word, bit 47 down to bit 0
    typedef struct packed {
        logic [7:0]  frame_len;     // Words counted after a header
        logic [15:0] frame_hdr;     // Header pattern
        logic        filter_en;     // Input pre-filter
        logic        high_sens;     // Sensitivity mode
        logic        ext_en;        // 48-bit extended register
        logic        hdr_len16;     // Header length 16 bits
        logic        frame_cnt_en;  // Frame length counting
        logic        hdr_rec_en;    // Header recognition
        logic        freeze_n;      // Output level freeze, low active
        logic [1:0]  clk_out_sel;   // Output clock divider
        logic        mains_async;   // Mains interfacing mode
        logic [1:0]  det_method;    // Detection method
        logic        zc_sync_en;    // Zero-crossing synchronisation
        logic [1:0]  det_time;      // Frequency detection time
        logic [1:0]  tx_timeout;    // Transmit time-out
        logic        watchdog_en;   // Watchdog enable
        logic        deviation;     // Frequency deviation
        logic [1:0]  baud;          // Symbol rate
        logic [2:0]  channel;       // Carrier channel
    } cfg_type;

    // Defaults: 132.5 kHz, 2400, dev 0.5, watchdog on, 1 s, 1 ms, preamble,
    // async mains, 4 MHz clock, freeze off, 16-bit header, normal length
    localparam logic [CFG_W-1:0] CFG_RESET = 48'h089B_5813_62D7;

    // Receive-side signals from the demodulator
    typedef struct packed {
        logic clk;          // Recovered bit clock
        logic data;         // Recovered data
        logic carrier;      // Carrier present
        logic preamble;     // Preamble present
        logic pll_locked;   // Bit-timing loop locked
        logic header_hit;   // Header matched, one-cycle pulse
    } rx_in_type;

    // Conditioned receive pins toward the host
    typedef struct packed {
        logic rx_bit_clock_out;
        logic rx_data_out;
        logic detect_indication_out;
    } rx_out_type;

    // Header recognition progress
    typedef enum logic [1:0] {
        HDR_IDLE  = 2'b00,
        HDR_PULSE = 2'b01,
        HDR_FRAME = 2'b10
    } hdr_state_type;

endpackage

//--- hw/rx_output_conditioner.sv
// Purpose: Conditions receive clock, data and detect pins per detection method
// Assumes: All inputs synchronous to aclk
// Notes:   Outputs registered, one cycle behind their causes
`timescale 1ns/100ps
module rx_output_conditioner (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [1:0]               method,
    input  wire logic                     uart_mode,
    input  wire logic                     hdr_rec,
    input  wire logic                     hdr_low,
    input  wire logic                     hdr_block,
    input  wire modem_cfg_pkg::rx_in_type rx_in,
    output modem_cfg_pkg::rx_out_type     rx_out
);
    import modem_cfg_pkg::*;

    logic det_src;      // Carrier or preamble, by method
    logic cond;         // Conditioning requested
    logic lock_ok;      // Loop lock counts only for preamble with conditioning
    logic quiet;        // Force clock and data to rest

    // Decode method; UART mode has its own encoding, carrier only
    always_comb begin
        det_src = rx_in.carrier;
        cond    = 1'b0;
        lock_ok = 1'b1;
        if (uart_mode) begin
            cond = (method == UDET_CARRIER_COND); // see RL20
        end else begin
            det_src = method[1] ? rx_in.preamble : rx_in.carrier; // see RL10 see RL12
            cond    = method[0]; // see RL11
            if (method == DET_PREAMBLE_COND) begin
                lock_ok = rx_in.pll_locked; // see RL13
            end
        end
        quiet = (cond && !(det_src && lock_ok)) || hdr_block;
    end

    // Output flops; data rests at the host-mode level, low in serial mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_out <= '0;
        end else begin
            rx_out.rx_bit_clock_out      <= quiet ? 1'b0 : rx_in.clk;
            rx_out.rx_data_out           <= quiet ? uart_mode : rx_in.data;
            rx_out.detect_indication_out <= hdr_rec ? !hdr_low : det_src; // see RL21
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    carrier_cond_low_a: assert property ( // see RL11
        !uart_mode && method == DET_CARRIER_COND && !rx_in.carrier
        |=> !rx_out.rx_bit_clock_out && !rx_out.rx_data_out)
        else $error("rx pins not forced low without carrier");

    unlock_quiet_a: assert property ( // see RL13
        !uart_mode && method == DET_PREAMBLE_COND && !rx_in.pll_locked
        |=> !rx_out.rx_bit_clock_out)
        else $error("rx clock active while loop unlocked");

    free_running_a: assert property ( // see RL10
        !uart_mode && method == DET_CARRIER && !hdr_block
        |=> rx_out.rx_bit_clock_out == $past(rx_in.clk))
        else $error("rx clock gated in unconditioned mode");

    header_detect_a: assert property ( // see RL21
        hdr_rec && hdr_low |=> !rx_out.detect_indication_out)
        else $error("detect not low on header");
endmodule

//--- verif/demod_model.sv
// Purpose: Demodulator stand-in on rx_in
// Assumes: Bench controls synchronous to aclk
// Notes:   Bit clock stands still while run is low
`timescale 1ns/100ps
module demod_model (
    input  wire logic                aclk,
    input  wire logic                run,
    input  wire logic                carrier,
    input  wire logic                preamble,
    input  wire logic                locked,
    input  wire logic                hit,
    input  wire logic [2:0]          half_per,
    output modem_cfg_pkg::rx_in_type rx_in
);
    import modem_cfg_pkg::*;
    logic [2:0] cnt_r = 3'h0;  // Cycles spent in this half bit
    initial rx_in = '0;
    // Status levels follow the bench controls one cycle later
    always @(posedge aclk) begin
        rx_in.carrier    <= carrier;
        rx_in.preamble   <= preamble;
        rx_in.pll_locked <= locked;
        rx_in.header_hit <= hit;
    end
    // Bit clock, half period set by half_per
    always @(posedge aclk) begin
        if (!run) begin
            cnt_r     <= 3'h0;
            rx_in.clk <= 1'h0;
        end else if (cnt_r == half_per) begin
            cnt_r      <= 3'h0;
            rx_in.clk  <= ~rx_in.clk;
            rx_in.data <= rx_in.clk ? rx_in.data : ~rx_in.data;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule

//--- verif/modem_config_register_tb_top.sv
// Purpose: Bench for the configuration register
// Assumes: Demodulator stand-in on rx_in
// Notes: Time-out code 11 never written
`timescale 1ns/100ps
module modem_config_register_tb_top;
    import modem_cfg_pkg::*;
    logic              aclk = 0, aresetn = 0, uart_mode = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [DATA_W-1:0] s_axi_wdata = 0, s_axi_rdata;
    logic [STRB_W-1:0] s_axi_wstrb = 0;
    logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic              s_axi_arvalid = 0, s_axi_rready = 0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              run = 0, carrier = 0, preamble = 0, locked = 0, hit = 0;
    logic [2:0]        half_per = 3'h3;
    rx_in_type         rx_in;
    rx_out_type        rx_out;
    cfg_type           cfg_eff;
    int                bad_count = 0, comparisons = 0;
    always #4 aclk = ~aclk;  // 125 MHz
    modem_config_register modem_config_register_i (.*);
    demod_model demod_model_i (.*);
    // Case equality: an unknown bit matches only an unknown in exp
    task automatic chk(input logic [47:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end while (!tb);
        s_axi_bready <= 0;
        chk(r, er, "bresp");
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] e, logic [1:0] er);
        logic ta, tb;
        logic [1:0] r;
        logic [31:0] d;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge aclk);
            {ta, tb, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
        end while (!tb);
        s_axi_rready <= 0;
        chk(d, e, "rdata");
        chk(r, er, "rresp");
    endtask
    task automatic test_reset();
        chk(cfg_eff, CFG_RESET, "defaults");
        rd(ADDR_CFG_LO, 32'h0013_62D7, RESP_OKAY);
        rd(ADDR_CFG_HI, 32'h0000_0000, RESP_OKAY);
        $display("test_reset done");
    endtask
    task automatic test_ext();
        wr(ADDR_CFG_HI, 32'hFF12_3405, RESP_OKAY);
        rd(ADDR_CFG_HI, 32'h0000_0000, RESP_OKAY);
        wr(ADDR_CFG_LO, 32'h001D_62D7, RESP_OKAY);
        rd(ADDR_CFG_LO, 32'h001D_62D7, RESP_OKAY);
        chk(cfg_eff.freeze_n, 1'h1, "freeze idle");
        chk({cfg_eff.hdr_rec_en, cfg_eff.frame_cnt_en}, 2'h0, "hdr idle");
        wr(ADDR_CFG_LO, 32'h003D_62D7, RESP_OKAY);
        @(negedge aclk);
        chk({cfg_eff.freeze_n, cfg_eff.hdr_rec_en}, 2'h1, "ext freeze hdr");
        chk(cfg_eff.frame_cnt_en, 1'h1, "ext count");
        wr(ADDR_CFG_LO, 32'h0039_62D7, RESP_OKAY);
        @(negedge aclk);
        chk(cfg_eff.frame_cnt_en, 1'h0, "count needs hdr");
        wr(ADDR_CFG_HI, 32'hFF12_3405, RESP_OKAY);
        rd(ADDR_CFG_HI, 32'h0012_3405, RESP_OKAY);
        chk(cfg_eff.frame_hdr, 16'h3405, "hdr value");
        wr(ADDR_CFG_LO, 32'h0013_62D7, RESP_OKAY);
        $display("test_ext done");
    endtask
    task automatic test_bus();
        wr(8'h0C, 32'h0000_0001, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h0000_0001, RESP_SLVERR);
        rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
        rd(ADDR_CFG_LO, 32'h0013_62D7, RESP_OKAY);
        $display("test_bus done");
    endtask
    // Preamble only, loop unlocked; runs 4 and 5 in UART mode
    task automatic test_methods();
        int n;
        logic p;
        logic [5:0] det = 6'b00_1100, free = 6'b01_0101;
        preamble <= 1;
        run      <= 1;
        for (int i = 0; i < 6; i++) begin
            uart_mode <= (i > 3);
            wr(ADDR_CFG_LO, 32'h0013_42D7 | (((i > 3) ? i - 2 : i) << 12), RESP_OKAY);
            repeat (2) @(negedge aclk);
            n = 0;
            p = rx_out.rx_bit_clock_out;
            repeat (16) begin
                @(negedge aclk);
                if (rx_out.rx_bit_clock_out !== p) n++;
                p = rx_out.rx_bit_clock_out;
            end
            chk(rx_out.detect_indication_out, det[i], "detect");
            chk(n > 0, free[i], "clock free");
        end
        uart_mode <= 0;
        $display("test_methods done");
    endtask
    task automatic test_header();
        logic seen;
        half_per <= 3'h7;
        wr(ADDR_CFG_LO, 32'h0037_62D7, RESP_OKAY);
        repeat (2) @(negedge aclk);
        chk(rx_out.detect_indication_out, 1'h1, "detect idle");
        @(posedge aclk);
        hit <= 1;
        @(posedge aclk);
        hit <= 0;
        seen = 0;
        repeat (6) begin
            @(negedge aclk);
            if (rx_out.detect_indication_out === 1'h0) seen = 1;
        end
        chk(seen, 1'h1, "hdr detect");
        $display("test_header done");
    endtask
    task automatic test_done();
        $display("Counts: comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        test_reset();
        test_ext();
        test_bus();
        test_methods();
        test_header();
        test_done();
    end
    // Hang guard, far beyond the scenarios' length
    initial begin
        #200000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end
endmodule
